// [hw/stp_pkg.sv]
// How it works
// RQ1 - Hold ramps to stop; resume only if error-free
// RQ2 - After hold, any new move may start
// RQ3 - Held jog takes new speeds and rates
// RQ4 - Held registration move can never restart
// RQ5 - Held abs/rel take new rates, keep target
// RQ6 - Held blend/dwell stops, not resumable, list kept
// RQ7 - Rates in steps/s/ms, times 1000 gives s^2
// RQ8 - Speed rises linearly from start toward programmed
// RQ9 - Accel ramp time and steps from speed difference
// RQ10 - Decel ramp uses own rate, same formula
// RQ11 - Ramps shorter than move: trapezoid, cruise between
// RQ12 - Ramps equal move: triangle, one step at top
// RQ13 - Ramps exceed move: triangle, never reaches top
// RQ14 - Host picks start speed near sqrt of accel
// RQ15 - Hold acts at once, never waits for input
// RQ16 - Hold ramps down at decel to start speed
`default_nettype none
package stp_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS = 50;               // 20 MHz clock period
  localparam int unsigned MS_NS = 1000000;           // Ramp update interval
  localparam int unsigned MS_CYC = MS_NS / CLK_NS;   // Cycles per millisecond
  localparam int unsigned ACC_SCALE = 1000;          // Rate unit to steps/s^2
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SPD_W = 20;                // Steps per second
  localparam int unsigned ACC_W = 16;                // Steps per second per ms
  localparam int unsigned POS_W = 32;
  localparam int unsigned IRQ_W = 3;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] VSTART_OFS = 8'h04;
  localparam logic [7:0] VPROG_OFS = 8'h08;
  localparam logic [7:0] ACCEL_OFS = 8'h0C;
  localparam logic [7:0] DECEL_OFS = 8'h10;
  localparam logic [7:0] TARGET_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] POS_OFS = 8'h1C;
  localparam logic [7:0] ISTS_OFS = 8'h20;
  localparam logic [7:0] IEN_OFS = 8'h24;
  localparam logic [7:0] ICLR_OFS = 8'h28;
  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int unsigned CT_TYPE_LSB = 0;           // Three bits of move type
  localparam int unsigned CT_IDX = 3;                // Wait for start input
  localparam int unsigned CT_START = 4;
  localparam int unsigned CT_HOLD = 5;
  localparam int unsigned CT_RESUME = 6;
  localparam int unsigned CT_STOP = 7;               // Controlled jog stop
  localparam int unsigned CT_CLRERR = 8;
  // ----------------------------------------------------------------
  // Interrupt bits
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_HELD = 1;
  localparam int unsigned IRQ_ERR = 2;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [SPD_W-1:0] VSTART_RST = 20'h00064;
  localparam logic [SPD_W-1:0] VPROG_RST = 20'h003E8;
  localparam logic [ACC_W-1:0] ACCEL_RST = 16'h0001;
  localparam logic [ACC_W-1:0] DECEL_RST = 16'h0001;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {MV_JOG, MV_ABS, MV_REL, MV_REG, MV_BLEND} move_t;
  typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_STOP, ST_HELD} state_t;
  typedef enum logic [1:0] {SH_TRAP, SH_TRI_TOP, SH_TRI_SHORT} shape_t;
endpackage
`default_nettype wire

// [hw/ms_tick.sv]
`default_nettype none
module ms_tick #(
  parameter int unsigned CYC = stp_pkg::MS_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Millisecond enable pulse
  output logic tick
);
  import stp_pkg::*;
  // State of the divider
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } tk_st_t;
  tk_st_t s_q;
  tk_st_t s_d;
  // Count cycles, pulse on wrap
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 32'(CYC - 1)) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h00000001;
    end
  end
  // Register state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick = s_q.tick;
  // Pulse coincides with counter wrap
  tick_wrap_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
    s_q.tick |-> s_q.cnt == 32'h00000000) else $error("tick not at wrap");
endmodule // ms_tick
`default_nettype wire

// [hw/step_rate.sv]
`default_nettype none
module step_rate #(
  parameter int unsigned MOD = stp_pkg::MS_CYC * stp_pkg::ACC_SCALE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Rate control
  input wire logic en,
  input wire logic [stp_pkg::SPD_W-1:0] speed,
  // Step pulse
  output logic step
);
  import stp_pkg::*;
  // Phase accumulator state
  typedef struct packed {
    logic [31:0] acc;
    logic step;
  } sr_st_t;
  sr_st_t s_q;
  sr_st_t s_d;
  logic [32:0] sum;
  // Add speed each cycle; speed steps per second's worth of cycles
  always_comb begin
    s_d = s_q;
    s_d.step = 1'b0;
    sum = 33'(s_q.acc) + 33'(speed);
    if (!en) begin
      s_d.acc = '0;
    end else if (sum >= 33'(MOD)) begin
      s_d.acc = 32'(sum - 33'(MOD));
      s_d.step = 1'b1;
    end else begin
      s_d.acc = sum[31:0];
    end
  end
  // Register state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign step = s_q.step;
  // Steps are isolated single-cycle pulses
  step_gap_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
    s_q.step |=> !s_q.step) else $error("step pulses back to back");
endmodule // step_rate
`default_nettype wire

// [hw/step_profile_hold_resume.sv]
`default_nettype none
module step_profile_hold_resume #(
  parameter int unsigned MS_CYCLES = stp_pkg::MS_CYC
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [stp_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Motion pins
  input wire logic START_IN,
  output logic STEP_OUT,
  output logic DIR_OUT,
  // Interrupt
  output logic IRQ
);
  import stp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    state_t st;
    move_t mtype;                 // Type of latched move
    logic idx;                    // Latched indexed option
    logic [SPD_W-1:0] vs;         // Starting speed
    logic [SPD_W-1:0] vp;         // Programmed speed
    logic [SPD_W-1:0] spd;        // Present step rate
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] dec;
    logic [POS_W-1:0] tgt;        // Target register
    logic [POS_W-1:0] pos;        // Signed position
    logic [POS_W-1:0] rem;        // Steps left in latched move
    logic dir;
    logic to_hold;                // Stop ends in held state
    logic err;
    logic hold_err;               // Error seen while stopping or held
    shape_t shape;
    logic [IRQ_W-1:0] ists;
    logic [IRQ_W-1:0] ien;
    logic irq;
    logic sin_m;                  // Start input synchroniser
    logic sin;
    logic sin_p;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } top_st_t;
  top_st_t s_q;
  top_st_t s_d;

  logic rst_m_q;                  // Reset release chain
  logic rst_q;
  logic rst_n;
  logic tick;                     // Millisecond enable
  logic step;                     // Step pulse
  logic wr_acc;                   // Write taking effect
  logic cmd_start, cmd_hold, cmd_resume, cmd_stop, cmd_clr;
  move_t nt;                      // Type in write data
  logic [POS_W-1:0] diff;
  logic [POS_W-1:0] len;
  logic [39:0] spd_sq, vs_sq, vp_sq;
  logic [63:0] kin, brk;
  logic near, brake, fin, can_res;
  logic [79:0] shp_l, shp_r;
  logic [SPD_W:0] up_sum, dn_sum;
  logic [SPD_W-1:0] flr;
  logic ev_done, ev_held, ev_err;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Two flops release the async reset synchronously
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_m_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_q <= rst_m_q;
    end
  end
  assign rst_n = rst_q;

  // ----------------------------------------------------------------
  // Rate helpers
  // ----------------------------------------------------------------
  ms_tick #(.CYC(MS_CYCLES)) ms_tick_inst (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .tick(tick)
  );
  step_rate #(.MOD(MS_CYCLES * ACC_SCALE)) step_rate_inst (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .en(s_q.st == ST_RUN || s_q.st == ST_STOP),
    .speed(s_q.spd),
    .step(step)
  );

  // ----------------------------------------------------------------
  // Decode and profile arithmetic
  // ----------------------------------------------------------------
  assign wr_acc = PSEL && PENABLE && PWRITE && s_q.pready;
  assign cmd_start = wr_acc && PADDR == CTRL_OFS && PWDATA[CT_START];
  assign cmd_hold = wr_acc && PADDR == CTRL_OFS && PWDATA[CT_HOLD];
  assign cmd_resume = wr_acc && PADDR == CTRL_OFS && PWDATA[CT_RESUME];
  assign cmd_stop = wr_acc && PADDR == CTRL_OFS && PWDATA[CT_STOP];
  assign cmd_clr = wr_acc && PADDR == CTRL_OFS && PWDATA[CT_CLRERR];
  assign nt = move_t'(PWDATA[CT_TYPE_LSB +: 3]);
  // Absolute moves measure from here, others are relative
  assign diff = (nt == MV_ABS) ? s_q.tgt - s_q.pos : s_q.tgt;
  assign len = diff[POS_W-1] ? POS_W'(-diff) : diff;
  assign spd_sq = 40'(s_q.spd) * 40'(s_q.spd);
  assign vs_sq = 40'(s_q.vs) * 40'(s_q.vs);
  assign vp_sq = 40'(s_q.vp) * 40'(s_q.vp);
  // Braking distance (v^2 - vs^2) / (2 * 1000 * dec) against steps left
  assign kin = 64'(spd_sq - vs_sq);
  assign brk = 64'(s_q.rem) * 64'(2 * ACC_SCALE) * 64'(s_q.dec); // RQ7 RQ10
  assign near = (s_q.mtype != MV_JOG) && (kin >= brk); // RQ11 RQ13
  assign brake = near || (s_q.spd > s_q.vp);
  assign fin = step && s_q.rem == 32'h00000001 && s_q.mtype != MV_JOG;
  // Shape: sum of ramp distances against move length
  assign shp_l = 80'(vp_sq - vs_sq) * 80'(17'(s_q.acc) + 17'(s_q.dec)); // RQ9 RQ10
  assign shp_r = 80'(len) * 80'(2 * ACC_SCALE) * 80'(s_q.acc) * 80'(s_q.dec);
  assign up_sum = (SPD_W+1)'(s_q.spd) + (SPD_W+1)'(s_q.acc);
  assign dn_sum = (SPD_W+1)'(s_q.spd) - (SPD_W+1)'(s_q.dec);
  assign flr = (s_q.st == ST_RUN && !near && s_q.spd > s_q.vp) ? s_q.vp : s_q.vs;
  // Only jog, absolute and relative moves resume, and only error-free
  assign can_res = !s_q.hold_err && (s_q.mtype == MV_JOG || s_q.mtype == MV_ABS ||
                   s_q.mtype == MV_REL); // RQ1 RQ4 RQ6

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    ev_done = 1'b0;
    ev_held = 1'b0;
    ev_err = 1'b0;
    // Start input passes two flops before edge detect
    s_d.sin_m = START_IN;
    s_d.sin = s_q.sin_m;
    s_d.sin_p = s_q.sin;
    // APB answer one cycle into the access phase
    s_d.pready = PSEL && PENABLE && !s_q.pready;
    s_d.pslverr = 1'b0;
    if (s_d.pready) begin
      s_d.pslverr = PADDR[1:0] != 2'b00 || PADDR > ICLR_OFS;
      unique case (PADDR)
        CTRL_OFS: s_d.prdata = 32'({s_q.idx, s_q.mtype});
        VSTART_OFS: s_d.prdata = 32'(s_q.vs);
        VPROG_OFS: s_d.prdata = 32'(s_q.vp);
        ACCEL_OFS: s_d.prdata = 32'(s_q.acc);
        DECEL_OFS: s_d.prdata = 32'(s_q.dec);
        TARGET_OFS: s_d.prdata = s_q.tgt;
        STATUS_OFS: s_d.prdata = 32'({s_q.shape, s_q.dir, can_res, s_q.hold_err,
                                       s_q.err, s_q.st});
        POS_OFS: s_d.prdata = s_q.pos;
        ISTS_OFS: s_d.prdata = 32'(s_q.ists);
        IEN_OFS: s_d.prdata = 32'(s_q.ien);
        default: s_d.prdata = '0;
      endcase
    end
    // Parameter writes checked before acceptance
    if (wr_acc) begin
      unique case (PADDR)
        VSTART_OFS: begin
          // Start speed fixed while a move is in motion
          if (PWDATA != 32'h0 && PWDATA <= 32'(s_q.vp) &&
              (s_q.st == ST_IDLE || s_q.st == ST_HELD)) begin
            s_d.vs = PWDATA[SPD_W-1:0];
          end else begin
            ev_err = 1'b1;
          end
        end
        VPROG_OFS: begin
          // New speed usable on resume
          if (PWDATA >= 32'(s_q.vs) && PWDATA[31:SPD_W] == '0) begin
            s_d.vp = PWDATA[SPD_W-1:0]; // RQ3 RQ5
          end else begin
            ev_err = 1'b1;
          end
        end
        ACCEL_OFS: begin
          if (PWDATA[ACC_W-1:0] != '0 && PWDATA[31:ACC_W] == '0) begin
            s_d.acc = PWDATA[ACC_W-1:0]; // RQ3 RQ5 RQ7
          end else begin
            ev_err = 1'b1;
          end
        end
        DECEL_OFS: begin
          if (PWDATA[ACC_W-1:0] != '0 && PWDATA[31:ACC_W] == '0) begin
            s_d.dec = PWDATA[ACC_W-1:0]; // RQ3 RQ5 RQ7
          end else begin
            ev_err = 1'b1;
          end
        end
        // Stored, but a held move keeps its latched distance
        TARGET_OFS: s_d.tgt = PWDATA; // RQ5
        IEN_OFS: s_d.ien = PWDATA[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    // Every step moves the position; steps of non-jog moves use up the move
    if (step) begin
      s_d.pos = s_q.dir ? s_q.pos - 32'h00000001 : s_q.pos + 32'h00000001;
      if (s_q.mtype != MV_JOG && s_q.rem != '0) begin
        s_d.rem = s_q.rem - 32'h00000001;
      end
    end
    if (cmd_start) begin
      if ((s_q.st == ST_IDLE || s_q.st == ST_HELD) &&
          PWDATA[CT_TYPE_LSB +: 3] <= 3'(MV_BLEND)) begin
        // New move from rest, also after a hold
        s_d.mtype = nt; // RQ2
        s_d.idx = PWDATA[CT_IDX];
        s_d.dir = diff[POS_W-1];
        s_d.rem = len;
        s_d.spd = s_q.vs;
        s_d.hold_err = 1'b0;
        s_d.to_hold = 1'b0;
        s_d.shape = (shp_l < shp_r) ? SH_TRAP : // RQ11
                    (shp_l == shp_r) ? SH_TRI_TOP : SH_TRI_SHORT; // RQ12 RQ13
        if (nt != MV_JOG && len == '0) begin
          s_d.st = ST_IDLE;
          ev_done = 1'b1;
        end else begin
          s_d.st = PWDATA[CT_IDX] ? ST_ARMED : ST_RUN;
        end
      end else begin
        ev_err = 1'b1;
      end
    end else begin
      unique case (s_q.st)
        ST_IDLE: begin
          if (cmd_resume) begin
            ev_err = 1'b1;
          end
        end
        ST_ARMED: begin
          // Hold cancels at once, input edge not awaited
          if (cmd_hold || cmd_stop) begin
            s_d.st = ST_IDLE; // RQ15
          end else if (s_q.sin && !s_q.sin_p) begin
            s_d.st = ST_RUN;
          end
        end
        ST_RUN: begin
          if (fin) begin
            s_d.st = ST_IDLE;
            ev_done = 1'b1;
          end else if (cmd_hold) begin
            s_d.st = ST_STOP; // RQ1 RQ15
            s_d.to_hold = 1'b1;
          end else if (cmd_stop && s_q.mtype == MV_JOG) begin
            s_d.st = ST_STOP;
          end else if (tick) begin
            // Linear ramp: add or remove one rate per millisecond
            if (brake) begin
              s_d.spd = (dn_sum[SPD_W] || dn_sum[SPD_W-1:0] < flr) ?
                        flr : dn_sum[SPD_W-1:0]; // RQ10 RQ12
            end else begin
              s_d.spd = (up_sum > (SPD_W+1)'(s_q.vp)) ?
                        s_q.vp : up_sum[SPD_W-1:0]; // RQ8 RQ9 RQ11
            end
          end
        end
        ST_STOP: begin
          if (fin) begin
            s_d.st = ST_IDLE;
            ev_done = 1'b1;
          end else begin
            if (cmd_hold) begin
              s_d.to_hold = 1'b1;
            end
            if (tick) begin
              // Ramp to start speed, then cease stepping
              if (s_q.spd == s_q.vs) begin
                s_d.st = (s_q.to_hold || cmd_hold) ? ST_HELD : ST_IDLE; // RQ16
                ev_held = s_q.to_hold || cmd_hold;
                ev_done = !(s_q.to_hold || cmd_hold);
              end else begin
                s_d.spd = (dn_sum[SPD_W] || dn_sum[SPD_W-1:0] < s_q.vs) ?
                          s_q.vs : dn_sum[SPD_W-1:0]; // RQ16
              end
            end
          end
        end
        ST_HELD: begin
          if (cmd_resume) begin
            if (can_res) begin
              // Resume from start speed with the present parameters
              s_d.st = ST_RUN; // RQ1 RQ3 RQ5
              s_d.spd = s_q.vs;
              s_d.to_hold = 1'b0;
            end else begin
              ev_err = 1'b1; // RQ4 RQ6
            end
          end
        end
      endcase
    end
    // Errors while held or stopping forbid a resume
    if (ev_err && (s_q.st == ST_HELD || s_q.st == ST_STOP)) begin
      s_d.hold_err = 1'b1; // RQ1
    end
    // Sticky flags: a new event wins over the clear
    s_d.err = (s_q.err && !cmd_clr) || ev_err;
    s_d.ists = s_q.ists & ~((wr_acc && PADDR == ICLR_OFS) ? PWDATA[IRQ_W-1:0] : '0);
    s_d.ists[IRQ_DONE] = s_d.ists[IRQ_DONE] || ev_done;
    s_d.ists[IRQ_HELD] = s_d.ists[IRQ_HELD] || ev_held;
    s_d.ists[IRQ_ERR] = s_d.ists[IRQ_ERR] || ev_err;
    s_d.irq = |(s_d.ists & s_d.ien);
  end

  // Register state
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.vs <= VSTART_RST;
      s_q.vp <= VPROG_RST;
      s_q.acc <= ACCEL_RST;
      s_q.dec <= DECEL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign STEP_OUT = step;
  assign DIR_OUT = s_q.dir;
  assign IRQ = s_q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n);
  sequence hold_in_run;
    s_q.st == ST_RUN && cmd_hold && !cmd_start && !fin;
  endsequence
  sequence held_resume(ok);
    s_q.st == ST_HELD && cmd_resume && !cmd_start && can_res == ok;
  endsequence
  hold_stop_a: assert property (hold_in_run |=> s_q.st == ST_STOP && s_q.to_hold) // RQ1
    else $error("hold did not start controlled stop");
  arm_hold_a: assert property (s_q.st == ST_ARMED && cmd_hold && !cmd_start // RQ15
    |=> s_q.st == ST_IDLE) else $error("hold waited on start input");
  stop_ramp_a: assert property (s_q.st == ST_STOP && s_d.st == ST_STOP // RQ16
    |=> s_q.spd <= $past(s_q.spd)) else $error("speed rose while stopping");
  stop_hold_a: assert property (s_q.st == ST_STOP && tick && s_q.to_hold && !fin && // RQ16
    s_q.spd == s_q.vs |=> s_q.st == ST_HELD ##1 !STEP_OUT) else $error("hold not reached");
  resume_bad_a: assert property (held_resume(1'b0) // RQ4
    |=> s_q.st == ST_HELD && s_q.err) else $error("refused resume not flagged");
  resume_ok_a: assert property (held_resume(1'b1) // RQ3
    |=> s_q.st == ST_RUN && s_q.spd == s_q.vs) else $error("resume not from start speed");
  held_rem_a: assert property (s_q.st == ST_HELD && !cmd_start // RQ5
    |=> s_q.rem == $past(s_q.rem)) else $error("held distance changed");
  restart_a: assert property (s_q.st == ST_HELD && cmd_start && // RQ2
    PWDATA[CT_TYPE_LSB +: 3] <= 3'(MV_BLEND) |=> s_q.st != ST_HELD)
    else $error("new move refused after hold");
  ramp_up_a: assert property (s_q.st == ST_RUN && tick && !brake && !fin && !cmd_hold && // RQ8
    !cmd_stop && !cmd_start && s_q.spd < s_q.vp |=> s_q.spd > $past(s_q.spd))
    else $error("speed did not rise");
  irq_lvl_a: assert property (IRQ == |(s_q.ists & s_q.ien))
    else $error("interrupt level mismatch");
endmodule // step_profile_hold_resume
`default_nettype wire

// [testbench/apb_host.sv]
`default_nettype none
// Host side: APB master that writes move commands
module apb_host (
  // Clock
  input wire logic clk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [stp_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  // One transfer; held until pready, idle cycle after it
  // Rates are written in steps/s/ms, never steps/s^2
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge clk);
  endtask
endmodule // apb_host
`default_nettype wire

// [testbench/step_profile_hold_resume_tb.sv]
`default_nettype none
module step_profile_hold_resume_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import stp_pkg::*;
  logic clk, rst_n, psel, pen, pwr, stp, dir, irq, rdy, serr, e, start_pin;
  logic [ADDR_W-1:0] pa;
  logic [31:0] pwd, prd, q;
  int error_cnt, cmp_count, steps, s0, p;
  step_profile_hold_resume #(.MS_CYCLES(20)) step_profile_hold_resume_inst (.SYS_CLK(clk),
    .ARST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd),
    .PRDATA(prd), .PREADY(rdy), .PSLVERR(serr), .START_IN(start_pin), .STEP_OUT(stp),
    .DIR_OUT(dir), .IRQ(irq));
  apb_host apb_host_inst (.clk(clk), .psel(psel), .penable(pen), .pwrite(pwr),
    .paddr(pa), .pwdata(pwd), .prdata(prd), .pready(rdy), .pslverr(serr));
  // Clock and step counter
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (stp === 1'b1) steps <= steps + 1;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb_host_inst.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    apb_host_inst.xfer(1'b0, a, 32'h0, q, e);
  endtask
  // Poll state under a bound
  task automatic wait_st(input logic [2:0] s);
    rd(STATUS_OFS);
    for (int i = 0; i < 4000 && q[2:0] !== s; i++) rd(STATUS_OFS);
    chk(q[2:0], s);
  endtask
  task automatic go(input logic [2:0] t);
    wr(CTRL_OFS, 32'h10 | t);
  endtask
  task automatic hold_to_stop();
    wr(CTRL_OFS, 32'h20);
    rd(STATUS_OFS);
    chk(q[2:0], ST_STOP);
    wait_st(ST_HELD);
    s0 = steps;
    repeat (300) @(posedge clk);
    chk(steps - s0, 0);
  endtask
  task automatic t_reset();
    rd(VSTART_OFS);
    chk(q, 32'h64);
    rd(VPROG_OFS);
    chk(q, 32'h3E8);
    rd(8'h2C);
    chk(e, 1'b1);
  endtask
  // Trapezoid, top triangle, short triangle
  task automatic t_shape();
    int len[3] = '{100, 24, 10};
    wr(VPROG_OFS, 1100);
    wr(ACCEL_OFS, 50);
    wr(DECEL_OFS, 50);
    wr(IEN_OFS, 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr(TARGET_OFS, len[i]);
      s0 = steps;
      go(MV_REL);
      rd(STATUS_OFS);
      chk(q[8:7], i);
      wait_st(ST_IDLE);
      chk(steps - s0, len[i]);
      chk(irq, 1'b1);
      wr(ICLR_OFS, 32'h7);
      chk(irq, 1'b0);
    end
  endtask
  // Indexed start waits for the pin edge; hold cancels the armed move at once
  task automatic t_index();
    wr(TARGET_OFS, 32'hFFFFFFF6);
    wr(CTRL_OFS, 32'h18 | MV_REL);
    rd(STATUS_OFS);
    chk(q[2:0], ST_ARMED);
    wr(CTRL_OFS, 32'h20);
    rd(STATUS_OFS);
    chk(q[2:0], ST_IDLE);
    s0 = steps;
    wr(CTRL_OFS, 32'h18 | MV_REL);
    start_pin <= 1'b1;
    wait_st(ST_IDLE);
    start_pin <= 1'b0;
    chk(steps - s0, 10);
    chk(dir, 1'b1);
  endtask
  task automatic t_jog();
    wr(IEN_OFS, 32'h2);
    wr(TARGET_OFS, 1);
    go(MV_JOG);
    repeat (2000) @(posedge clk);
    hold_to_stop();
    chk(irq, 1'b1);
    wr(VPROG_OFS, 800);
    rd(STATUS_OFS);
    chk(q[5:3], 3'h4);
    wr(CTRL_OFS, 32'h40);
    rd(STATUS_OFS);
    chk(q[2:0], ST_RUN);
    // Settled at the new speed: one step every 25 cycles
    repeat (400) @(posedge clk);
    s0 = steps;
    repeat (1000) @(posedge clk);
    chk(steps - s0, 40);
    hold_to_stop();
    // Resume, then a plain jog stop ends in idle
    wr(CTRL_OFS, 32'h40);
    wr(CTRL_OFS, 32'h80);
    wait_st(ST_IDLE);
    wr(ICLR_OFS, 32'h7);
  endtask
  // Registration and blend refuse resume
  task automatic t_nores(input logic [2:0] t);
    wr(TARGET_OFS, 400);
    go(t);
    rd(STATUS_OFS);
    chk(q[2:0], ST_RUN);
    repeat (400) @(posedge clk);
    hold_to_stop();
    wr(CTRL_OFS, 32'h40);
    rd(STATUS_OFS);
    chk(q[3:0], 4'hC);
    wr(CTRL_OFS, 32'h100);
  endtask
  task automatic t_abs();
    rd(POS_OFS);
    p = q;
    wr(TARGET_OFS, p + 200);
    go(MV_ABS);
    repeat (300) @(posedge clk);
    hold_to_stop();
    // New rates while held; start speed 100 is the root of 10000 steps/s^2
    wr(ACCEL_OFS, 10);
    wr(DECEL_OFS, 10);
    wr(TARGET_OFS, p + 5000);
    wr(CTRL_OFS, 32'h40);
    wait_st(ST_IDLE);
    rd(POS_OFS);
    chk(q, p + 200);
  endtask
  task automatic give_verdict();
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #4000000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    start_pin = 1'b0;
    steps = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_shape();
    t_index();
    t_jog();
    t_nores(MV_REG);
    t_nores(MV_BLEND);
    t_abs();
    give_verdict();
  end
endmodule // step_profile_hold_resume_tb
`default_nettype wire
